// *** verilog/trace_module_consts.svh ***
`ifndef TRACE_MODULE_CONSTS_SVH
`define TRACE_MODULE_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_COMPARATOR_A_HIGH 5'h00
`define OFS_COMPARATOR_A_LOW  5'h01
`define OFS_COMPARATOR_B_HIGH 5'h02
`define OFS_COMPARATOR_B_LOW  5'h03
`define OFS_TRACE_FIFO_HIGH   5'h04
`define OFS_TRACE_FIFO_LOW    5'h05
`define OFS_TRACE_CONTROL     5'h06
`define OFS_DEBUG_FORCE_RESET 5'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_TRACE_MODULE_ENABLE 7
`define BIT_CAPTURE_ARMED       6
`define BIT_FORCE_RESET         0

// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define RST_COMPARATOR       8'h00
`define RST_TRACE_CONTROL    8'h00
`define RST_BREAKPOINT       16'h0000
`define FORCE_RESET_READBACK 8'h00
`define ZERO_BYTE            8'h00

// ----------------------------------------
// Trace buffer shape
// ----------------------------------------
`define TRACE_FIFO_DEPTH 8
`define TRACE_FIFO_WIDTH 16

`endif

// *** verilog/trace_module_pkg.sv ***
package trace_module_pkg;

  typedef enum logic [1:0] {
    CMD_BREAKPOINT_READ  = 2'b00,
    CMD_BREAKPOINT_WRITE = 2'b01,
    CMD_BYTE_READ        = 2'b10,
    CMD_BYTE_WRITE       = 2'b11
  } serial_cmd_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [7:0]  wdata;
  } reg_access_s;

  typedef struct packed {
    logic        valid;
    serial_cmd_e cmd;
    logic [4:0]  addr;
    logic [15:0] data;
  } serial_request_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } opcode_fetch_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } trace_store_s;

endpackage

// *** verilog/trace_fifo_ring.sv ***
`timescale 1ns/1ps
module trace_fifo_ring #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_b,
  input  wire logic             i_restart,
  input  wire logic             i_store,
  input  wire logic [WIDTH-1:0] i_store_data,
  input  wire logic             i_advance,
  input  wire logic [WIDTH-1:0] i_profile_data,
  output logic      [WIDTH-1:0] o_head,
  output logic                  o_filled
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------
  // Storage and single ring pointer
  // ----------------------------------------
  // One pointer serves both sides: after a full capture it rests on the oldest
  // entry, and each profiling read overwrites the slot it just handed out.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_ptr;
  logic             write_en;
  logic [WIDTH-1:0] write_data;
  logic             last_slot;

  assign last_slot  = (ptr == PW'(DEPTH - 1));
  assign next_ptr   = last_slot ? '0 : PW'(ptr + 1'b1);
  assign write_en   = i_store | i_advance;
  assign write_data = i_store ? i_store_data : i_profile_data;
  assign o_head     = mem[ptr];

  always_ff @(posedge i_mclk) begin
    if (write_en) begin
      mem[ptr] <= write_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ptr <= '0;
    end else if (write_en) begin
      ptr <= next_ptr;
    end
  end

  // ----------------------------------------
  // Fill count for a capture run
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || i_restart) begin
      count    <= '0;
      o_filled <= 1'b0;
    end else begin
      o_filled <= i_store && (count == CW'(DEPTH - 1));
      if (i_store && count != CW'(DEPTH)) begin
        count <= CW'(count + 1'b1);
      end
    end
  end

endmodule

// *** verilog/debug_breakpoint_trace_regs.sv ***
`timescale 1ns/1ps
`include "trace_module_consts.svh"

// Function
// - Breakpoint address is 16 bits, reached only by serial breakpoint commands.
// - Breakpoint compare gated by enable bit, request type by force/tag select.
// - Force-reset register takes writes from serial byte-write only, never from CPU.
// - Force-reset register always reads back 0x00.
// - Host writing 1 to bit 0 of force-reset triggers full system reset.
// - Seven bytes of CPU-visible register space: comparators, FIFO, control.
// - Comparator bytes reset to 0x00, always readable, write-locked while armed.
// - FIFO high byte read-only; reads 0x00 in event-only modes.
// - Reading FIFO high byte never moves the FIFO.
// - Reading FIFO low byte advances to next word; writes do nothing.
// - Event-only capture stores just a byte per entry, upper half zero.
// - While armed, low-byte reads leave the FIFO where it is.
// - Unarmed low-byte read stores last fetched opcode address in last slot.
// - Ninth profiling read returns what the first read stored.
// - Control register readable and writable at all times.
// - Control bit 7 enables the module; cannot be set while device secure.
// - Armed bit set by software, cleared by run completion or writing zero.
module debug_breakpoint_trace_regs #(
  parameter int FIFO_DEPTH = `TRACE_FIFO_DEPTH,
  parameter int FIFO_WIDTH = `TRACE_FIFO_WIDTH
) (
  input  wire logic                             i_mclk,
  input  wire logic                             i_rst_b,
  input  wire trace_module_pkg::reg_access_s    i_cpu_access,
  input  wire trace_module_pkg::serial_request_s i_serial_req,
  input  wire trace_module_pkg::opcode_fetch_s  i_fetch,
  input  wire trace_module_pkg::trace_store_s   i_trace_store,
  input  wire logic                             i_event_only,
  input  wire logic                             i_run_done,
  input  wire logic                             i_mcu_secure,
  input  wire logic                             i_breakpoint_enable_bit,
  input  wire logic                             i_force_tag_select,
  output logic      [7:0]                       o_cpu_rdata,
  output logic      [15:0]                      o_serial_rdata,
  output logic                                  o_serial_done,
  output logic                                  o_force_reset,
  output logic                                  o_break_request,
  output logic                                  o_break_tag,
  output logic      [15:0]                      o_comparator_a,
  output logic      [15:0]                      o_comparator_b,
  output logic      [7:0]                       o_trace_control
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] breakpoint_match_address;
  logic [7:0]  comparator_a_high;
  logic [7:0]  comparator_a_low;
  logic [7:0]  comparator_b_high;
  logic [7:0]  comparator_b_low;
  logic [7:0]  trace_control;
  logic [15:0] last_opcode_addr;
  logic [7:0]  next_trace_control;

  // ----------------------------------------
  // Serial command decode
  // ----------------------------------------
  logic serial_bkpt_read;
  logic serial_bkpt_write;
  logic serial_byte_read;
  logic serial_byte_write;
  logic serial_mem;

  assign serial_bkpt_read  = i_serial_req.valid &&
                             (i_serial_req.cmd == trace_module_pkg::CMD_BREAKPOINT_READ);
  assign serial_bkpt_write = i_serial_req.valid &&
                             (i_serial_req.cmd == trace_module_pkg::CMD_BREAKPOINT_WRITE);
  assign serial_byte_read  = i_serial_req.valid &&
                             (i_serial_req.cmd == trace_module_pkg::CMD_BYTE_READ);
  assign serial_byte_write = i_serial_req.valid &&
                             (i_serial_req.cmd == trace_module_pkg::CMD_BYTE_WRITE);
  assign serial_mem        = serial_byte_read | serial_byte_write;

  // ----------------------------------------
  // Shared register access
  // ----------------------------------------
  // A serial memory access takes the register port for its cycle; the CPU
  // access in that same cycle is dropped rather than queued.
  logic       acc_rd;
  logic       acc_wr;
  logic [4:0] acc_addr;
  logic [7:0] acc_wdata;
  logic       cpu_rd;

  assign acc_rd    = serial_mem ? serial_byte_read  : i_cpu_access.rd;
  assign acc_wr    = serial_mem ? serial_byte_write : i_cpu_access.wr;
  assign acc_addr  = serial_mem ? i_serial_req.addr : i_cpu_access.addr;
  assign acc_wdata = serial_mem ? i_serial_req.data[7:0] : i_cpu_access.wdata;
  assign cpu_rd    = !serial_mem && i_cpu_access.rd;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic hit_ca_high;
  logic hit_ca_low;
  logic hit_cb_high;
  logic hit_cb_low;
  logic hit_fifo_high;
  logic hit_fifo_low;
  logic hit_control;
  logic hit_force_reset;

  assign hit_ca_high     = (acc_addr == `OFS_COMPARATOR_A_HIGH);
  assign hit_ca_low      = (acc_addr == `OFS_COMPARATOR_A_LOW);
  assign hit_cb_high     = (acc_addr == `OFS_COMPARATOR_B_HIGH);
  assign hit_cb_low      = (acc_addr == `OFS_COMPARATOR_B_LOW);
  assign hit_fifo_high   = (acc_addr == `OFS_TRACE_FIFO_HIGH);
  assign hit_fifo_low    = (acc_addr == `OFS_TRACE_FIFO_LOW);
  assign hit_control     = (acc_addr == `OFS_TRACE_CONTROL);
  assign hit_force_reset = (acc_addr == `OFS_DEBUG_FORCE_RESET);

  // ----------------------------------------
  // Control and capture state
  // ----------------------------------------
  logic capture_armed;
  logic trace_module_enable;
  logic comparator_write_ok;
  logic control_write;
  logic new_enable;
  logic new_armed;
  logic arm_start;
  logic fifo_filled;
  logic run_complete;

  assign capture_armed       = trace_control[`BIT_CAPTURE_ARMED];
  assign trace_module_enable = trace_control[`BIT_TRACE_MODULE_ENABLE];
  assign comparator_write_ok = acc_wr && !capture_armed;
  assign control_write       = acc_wr && hit_control;
  assign new_enable          = acc_wdata[`BIT_TRACE_MODULE_ENABLE] && !i_mcu_secure;
  // Arming needs the module enabled, otherwise no store could ever fill the FIFO
  assign new_armed           = acc_wdata[`BIT_CAPTURE_ARMED] && new_enable;
  assign arm_start           = control_write && new_armed && !capture_armed;
  assign run_complete        = capture_armed && (fifo_filled || i_run_done);

  always_comb begin
    next_trace_control = trace_control;
    if (run_complete) begin
      next_trace_control[`BIT_CAPTURE_ARMED] = 1'b0;
    end
    // A software write in the completion cycle wins, so a re-arm is not lost
    if (control_write) begin
      next_trace_control = acc_wdata;
      next_trace_control[`BIT_TRACE_MODULE_ENABLE] = new_enable;
      next_trace_control[`BIT_CAPTURE_ARMED]       = new_armed;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      trace_control <= `RST_TRACE_CONTROL;
    end else begin
      trace_control <= next_trace_control;
    end
  end

  // ----------------------------------------
  // Comparator registers
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      comparator_a_high <= `RST_COMPARATOR;
      comparator_a_low  <= `RST_COMPARATOR;
      comparator_b_high <= `RST_COMPARATOR;
      comparator_b_low  <= `RST_COMPARATOR;
    end else if (comparator_write_ok) begin
      if (hit_ca_high) begin
        comparator_a_high <= acc_wdata;
      end
      if (hit_ca_low) begin
        comparator_a_low <= acc_wdata;
      end
      if (hit_cb_high) begin
        comparator_b_high <= acc_wdata;
      end
      if (hit_cb_low) begin
        comparator_b_low <= acc_wdata;
      end
    end
  end

  // ----------------------------------------
  // Trace FIFO
  // ----------------------------------------
  logic                  fifo_store;
  logic                  fifo_advance;
  logic [FIFO_WIDTH-1:0] fifo_store_data;
  logic [FIFO_WIDTH-1:0] fifo_head;
  logic [7:0]            fifo_high_view;

  assign fifo_store      = capture_armed && trace_module_enable && i_trace_store.valid;
  assign fifo_store_data = i_event_only ? {`ZERO_BYTE, i_trace_store.data[7:0]}
                                        : i_trace_store.data;
  // High-byte reads and CPU writes never reach the pointer
  assign fifo_advance    = acc_rd && hit_fifo_low && !capture_armed;
  assign fifo_high_view  = i_event_only ? `ZERO_BYTE : fifo_head[15:8];

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      last_opcode_addr <= `RST_BREAKPOINT;
    end else if (i_fetch.valid) begin
      last_opcode_addr <= i_fetch.addr;
    end
  end

  // Profiling overwrites the slot it hands out, so after eight reads the
  // ring wraps to the first stored address
  trace_fifo_ring #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_trace_fifo_ring (
    .i_mclk         (i_mclk),
    .i_rst_b        (i_rst_b),
    .i_restart      (arm_start),
    .i_store        (fifo_store),
    .i_store_data   (fifo_store_data),
    .i_advance      (fifo_advance),
    .i_profile_data (last_opcode_addr),
    .o_head         (fifo_head),
    .o_filled       (fifo_filled)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Offsets outside the map, including the unused trigger slots, read zero
  logic [7:0] read_mux;

  assign read_mux = hit_ca_high     ? comparator_a_high :
                    hit_ca_low      ? comparator_a_low :
                    hit_cb_high     ? comparator_b_high :
                    hit_cb_low      ? comparator_b_low :
                    hit_fifo_high   ? fifo_high_view :
                    hit_fifo_low    ? fifo_head[7:0] :
                    hit_control     ? trace_control :
                    hit_force_reset ? `FORCE_RESET_READBACK :
                                      `ZERO_BYTE;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_cpu_rdata <= `ZERO_BYTE;
    end else if (cpu_rd) begin
      o_cpu_rdata <= read_mux;
    end
  end

  // ----------------------------------------
  // Force reset
  // ----------------------------------------
  // Only the serial byte-write path can reach this bit; a CPU write to the
  // same offset is simply dropped
  logic force_reset_hit;

  assign force_reset_hit = serial_byte_write && hit_force_reset &&
                           i_serial_req.data[`BIT_FORCE_RESET];

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_force_reset <= 1'b0;
    end else begin
      o_force_reset <= force_reset_hit;
    end
  end

  // ----------------------------------------
  // Breakpoint register and serial answers
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      breakpoint_match_address <= `RST_BREAKPOINT;
    end else if (serial_bkpt_write) begin
      breakpoint_match_address <= i_serial_req.data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_serial_rdata <= `RST_BREAKPOINT;
      o_serial_done  <= 1'b0;
    end else begin
      o_serial_done <= i_serial_req.valid;
      if (serial_bkpt_read) begin
        o_serial_rdata <= breakpoint_match_address;
      end else if (serial_byte_read) begin
        o_serial_rdata <= {`ZERO_BYTE, read_mux};
      end
    end
  end

  // ----------------------------------------
  // Breakpoint compare
  // ----------------------------------------
  logic breakpoint_hit;

  assign breakpoint_hit = i_breakpoint_enable_bit && i_fetch.valid &&
                          (i_fetch.addr == breakpoint_match_address);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_break_request <= 1'b0;
      o_break_tag     <= 1'b0;
    end else begin
      o_break_request <= breakpoint_hit;
      o_break_tag     <= i_force_tag_select;
    end
  end

  // ----------------------------------------
  // Outputs straight from state
  // ----------------------------------------
  assign o_comparator_a  = {comparator_a_high, comparator_a_low};
  assign o_comparator_b  = {comparator_b_high, comparator_b_low};
  assign o_trace_control = trace_control;

endmodule

// *** testbench/debug_breakpoint_trace_regs_checker.sv ***
`timescale 1ns/1ps
`include "trace_module_consts.svh"
module debug_breakpoint_trace_regs_checker (
  input wire logic                              i_mclk,
  input wire logic                              i_rst_b,
  input wire trace_module_pkg::reg_access_s     i_cpu_access,
  input wire trace_module_pkg::serial_request_s i_serial_req,
  input wire trace_module_pkg::opcode_fetch_s   i_fetch,
  input wire logic                              i_mcu_secure,
  input wire logic                              i_breakpoint_enable_bit,
  input wire logic                              i_force_tag_select,
  input wire logic [7:0]                        o_cpu_rdata,
  input wire logic [15:0]                       o_serial_rdata,
  input wire logic                              o_force_reset,
  input wire logic                              o_break_request,
  input wire logic                              o_break_tag,
  input wire logic [15:0]                       o_comparator_a,
  input wire logic [15:0]                       o_comparator_b,
  input wire logic [7:0]                        o_trace_control
);
  // ----------
  // Decodes
  // ----------
  wire logic srq = i_serial_req.valid;
  wire logic frc = srq && i_serial_req.cmd == trace_module_pkg::CMD_BYTE_WRITE
                   && i_serial_req.addr == `OFS_DEBUG_FORCE_RESET && i_serial_req.data[0];
  wire logic bkw = srq && i_serial_req.cmd == trace_module_pkg::CMD_BREAKPOINT_WRITE;
  wire logic bkr = srq && i_serial_req.cmd == trace_module_pkg::CMD_BREAKPOINT_READ;
  wire logic frd = i_cpu_access.rd && !srq && i_cpu_access.addr == `OFS_DEBUG_FORCE_RESET;
  wire logic arm = o_trace_control[`BIT_CAPTURE_ARMED];
  wire logic ena = o_trace_control[`BIT_TRACE_MODULE_ENABLE];

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  // ----------
  // Properties
  // ----------
  property p_force_pulse;
    frc |=> o_force_reset;
  endproperty
  a_force_pulse: assert property (p_force_pulse) else $error("no force reset");
  property p_force_src;
    o_force_reset |-> $past(frc);
  endproperty
  a_force_src: assert property (p_force_src) else $error("stray force reset");
  property p_bkpt_rw;
    bkw ##2 bkr |=> o_serial_rdata == $past(i_serial_req.data, 3);
  endproperty
  a_bkpt_rw: assert property (p_bkpt_rw) else $error("breakpoint readback");
  property p_force_read;
    frd |=> o_cpu_rdata == `FORCE_RESET_READBACK;
  endproperty
  a_force_read: assert property (p_force_read) else $error("force reset read");
  property p_cmp_lock;
    arm |=> $stable(o_comparator_a) && $stable(o_comparator_b);
  endproperty
  a_cmp_lock: assert property (p_cmp_lock) else $error("comparator written");
  property p_secure;
    i_mcu_secure && !ena |=> !ena;
  endproperty
  a_secure: assert property (p_secure) else $error("enable set while secure");
  property p_armed_en;
    arm |-> ena;
  endproperty
  a_armed_en: assert property (p_armed_en) else $error("armed without enable");
  property p_break;
    o_break_request |-> $past(i_fetch.valid) && $past(i_breakpoint_enable_bit)
                        && o_break_tag == $past(i_force_tag_select);
  endproperty
  a_break: assert property (p_break) else $error("bad break request");
endmodule

bind debug_breakpoint_trace_regs debug_breakpoint_trace_regs_checker i_chk (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cpu_access(i_cpu_access),
  .i_serial_req(i_serial_req), .i_fetch(i_fetch), .i_mcu_secure(i_mcu_secure),
  .i_breakpoint_enable_bit(i_breakpoint_enable_bit), .i_force_tag_select(i_force_tag_select),
  .o_cpu_rdata(o_cpu_rdata), .o_serial_rdata(o_serial_rdata), .o_force_reset(o_force_reset),
  .o_break_request(o_break_request), .o_break_tag(o_break_tag),
  .o_comparator_a(o_comparator_a), .o_comparator_b(o_comparator_b),
  .o_trace_control(o_trace_control)
);

// *** testbench/debug_host_model.sv ***
`timescale 1ns/1ps
module debug_host_model (
  input  wire logic                         i_mclk,
  output trace_module_pkg::serial_request_s o_req
);
  initial o_req = '0;
  // Released address and data go inverted so a stale value is never mistaken for a live one
  task automatic send(input trace_module_pkg::serial_cmd_e cmd, input logic [4:0] a,
                      input logic [15:0] d);
    @(posedge i_mclk);
    o_req <= '{valid: 1'b1, cmd: cmd, addr: a, data: d};
    @(posedge i_mclk);
    o_req <= '{valid: 1'b0, cmd: cmd, addr: ~a, data: ~d};
  endtask
endmodule

// *** testbench/debug_breakpoint_trace_regs_tb.sv ***
`timescale 1ns/1ps
`include "trace_module_consts.svh"
module debug_breakpoint_trace_regs_tb;
  // ----------
  // Signals
  // ----------
  localparam logic [4:0] FH  = `OFS_TRACE_FIFO_HIGH;
  localparam logic [4:0] FL  = `OFS_TRACE_FIFO_LOW;
  localparam logic [4:0] CTL = `OFS_TRACE_CONTROL;
  localparam logic [4:0] FRS = `OFS_DEBUG_FORCE_RESET;
  logic                              i_mclk;
  logic                              i_rst_b;
  trace_module_pkg::reg_access_s     acc;
  trace_module_pkg::serial_request_s sreq;
  trace_module_pkg::opcode_fetch_s   fet;
  trace_module_pkg::trace_store_s    sto;
  logic                              evt, done, sec, bk_en, tag, frc, brk, brk_tag, ser_done;
  logic [7:0]                        cpu_rd, ctrl;
  logic [15:0]                       ser_rd, cmp_a, cmp_b, bk, fa;
  logic [15:0]                       cap [8];
  logic [7:0]                        cb [4];
  logic [8:0]                        cpu_q [$];
  logic [16:0]                       ser_q [$];
  logic [8:0]                        cn;
  logic [16:0]                       sn;
  logic                              rd_d;
  int                                mismatches, num_checks, seed;

  debug_breakpoint_trace_regs i_dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cpu_access(acc), .i_serial_req(sreq),
    .i_fetch(fet), .i_trace_store(sto), .i_event_only(evt), .i_run_done(done),
    .i_mcu_secure(sec), .i_breakpoint_enable_bit(bk_en), .i_force_tag_select(tag),
    .o_cpu_rdata(cpu_rd), .o_serial_rdata(ser_rd), .o_serial_done(ser_done),
    .o_force_reset(frc), .o_break_request(brk), .o_break_tag(brk_tag),
    .o_comparator_a(cmp_a), .o_comparator_b(cmp_b), .o_trace_control(ctrl)
  );
  debug_host_model i_host (.i_mclk(i_mclk), .o_req(sreq));

  // ----------
  // Tasks
  // ----------
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cpu(input logic w, input logic [4:0] a, input logic [7:0] d, input logic c);
    @(posedge i_mclk);
    acc <= '{rd: ~w, wr: w, addr: a, wdata: w ? d : 8'h00};
    if (!w) cpu_q.push_back({c, d});
    @(posedge i_mclk);
    acc <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e); cpu(1'b0, a, e, 1'b1); endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d); cpu(1'b1, a, d, 1'b0); endtask
  task automatic ser(input trace_module_pkg::serial_cmd_e c, input logic [4:0] a,
                     input logic [15:0] d, input logic [15:0] e);
    ser_q.push_back({~c[0], e});
    i_host.send(c, a, d);
  endtask
  task automatic fetch(input logic [15:0] a, input logic en, input logic tg);
    @(posedge i_mclk);
    fet <= '{valid: 1'b1, addr: a};
    bk_en <= en;
    tag <= tg;
    @(posedge i_mclk);
    fet <= '{valid: 1'b0, addr: ~a};
  endtask
  task automatic capture(input logic ev);
    @(posedge i_mclk);
    evt <= ev;
    wr(CTL, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      cap[i] = 16'($random(seed));
      @(posedge i_mclk);
      sto <= '{valid: 1'b1, data: cap[i]};
      @(posedge i_mclk);
      sto <= '{valid: 1'b0, data: ~cap[i]};
    end
    // Armed drops one cycle after the last store is taken; allow two extra
    repeat (3) @(posedge i_mclk);
    rd(CTL, 8'h80);
  endtask

  // Result watcher: every settled read answer takes the oldest note
  always @(posedge i_mclk) begin
    rd_d <= acc.rd;
    if (rd_d === 1'b1 && cpu_q.size() > 0) begin
      cn = cpu_q.pop_front();
      if (cn[8]) chk("cpu_rdata", {8'h00, cpu_rd}, {8'h00, cn[7:0]});
    end
    if (ser_done === 1'b1 && ser_q.size() > 0) begin
      sn = ser_q.pop_front();
      if (sn[16]) chk("serial_rdata", ser_rd, sn[15:0]);
    end
  end

  // ----------
  // Sequence
  // ----------
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  initial begin
    #500000;
    mismatches++;
    close_out();
  end
  initial begin
    seed = 60;
    i_rst_b = 1'b0;
    acc = '0;
    fet = '0;
    sto = '0;
    {evt, done, sec, bk_en, tag, rd_d} = '0;
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    for (int a = 0; a < 4; a++) rd(5'(a), `RST_COMPARATOR);
    rd(CTL, `RST_TRACE_CONTROL);
    rd(FRS, 8'h00);
    rd(5'h07, 8'h00);
    for (int a = 0; a < 4; a++) begin
      cb[a] = 8'($random(seed));
      wr(5'(a), cb[a]);
      rd(5'(a), cb[a]);
    end
    chk("comparator_a", cmp_a, {cb[0], cb[1]});
    chk("comparator_b", cmp_b, {cb[2], cb[3]});
    wr(FRS, 8'h01);
    #1 chk("force_reset", {15'h0, frc}, 16'h0000);
    ser(trace_module_pkg::CMD_BYTE_WRITE, FRS, 16'h0001, 16'h0000);
    #1 chk("force_reset", {15'h0, frc}, 16'h0001);
    ser(trace_module_pkg::CMD_BYTE_READ, FRS, 16'h0000, 16'h0000);
    bk = 16'($random(seed));
    ser(trace_module_pkg::CMD_BREAKPOINT_WRITE, 5'h00, bk, 16'h0000);
    ser(trace_module_pkg::CMD_BREAKPOINT_READ, 5'h00, 16'h0000, bk);
    fetch(bk, 1'b1, 1'b1);
    #1 chk("break", {14'h0, brk, brk_tag}, 16'h0003);
    fetch(bk, 1'b0, 1'b0);
    #1 chk("break", {15'h0, brk}, 16'h0000);
    fetch(~bk, 1'b1, 1'b0);
    #1 chk("break", {15'h0, brk}, 16'h0000);
    @(posedge i_mclk);
    sec <= 1'b1;
    wr(CTL, 8'hA5);
    rd(CTL, 8'h25);
    @(posedge i_mclk);
    sec <= 1'b0;
    wr(CTL, 8'hA5);
    rd(CTL, 8'hA5);
    wr(CTL, 8'hC0);
    wr(CTL, 8'h80);
    rd(CTL, 8'h80);
    wr(CTL, 8'hC0);
    @(posedge i_mclk);
    done <= 1'b1;
    @(posedge i_mclk);
    done <= 1'b0;
    rd(CTL, 8'h80);
    wr(CTL, 8'hC0);
    wr(5'h00, ~cb[0]);
    rd(5'h00, cb[0]);
    // Content at the head is not defined while armed; only the position matters
    cpu(1'b0, FL, 8'h00, 1'b0);
    capture(1'b0);
    wr(FH, 8'hFF);
    wr(FL, 8'hFF);
    fa = 16'($random(seed));
    fetch(fa, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rd(FH, cap[i][15:8]);
      rd(FH, cap[i][15:8]);
      rd(FL, cap[i][7:0]);
    end
    for (int i = 0; i < 8; i++) begin
      rd(FH, fa[15:8]);
      rd(FL, fa[7:0]);
    end
    capture(1'b1);
    for (int i = 0; i < 8; i++) begin
      rd(FH, `ZERO_BYTE);
      rd(FL, cap[i][7:0]);
    end
    repeat (4) @(posedge i_mclk);
    chk("pending", 16'(cpu_q.size() + ser_q.size()), 16'h0000);
    close_out();
  end
endmodule
